// ---- src/acc_i2c_port.sv ----
/*
  Two-wire slave port of a three-axis accelerometer with its two interrupt
  pins. Assumes the register file answers reg_rdata_i combinationally for
  reg_addr_o, and that event inputs come from logic on ref_clk_i.
*/
`timescale 1ns/1ps
`include "acc_map.svh"
module acc_i2c_port
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_lsb_select_i,
  input wire logic fast_read_i,
  output logic [7:0] reg_addr_o,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_rd_stb_o,
  output logic wr_valid_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  input wire logic wr_ready_i,
  input wire logic sample_ready_i,
  input wire logic [5:0] ev_flags_i,
  input wire logic [5:0] ev_enable_i,
  input wire logic [5:0] ev_route_a_i,
  output logic drdy_o,
  output logic irq_out_a_o,
  output logic irq_out_b_o
);

  typedef struct packed
  {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic sel_m;
    logic sel_s;
    acc_pkg::acc_state_e state;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rw;
    logic first;
    logic go_on;
    logic [7:0] ptr;
    logic oe;
    logic drdy;
    logic irq_a;
    logic irq_b;
    logic push;
    acc_pkg::acc_word_s push_word;
    logic rd_stb;
  } acc_port_s;

  acc_port_s st_reg;
  acc_port_s st_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [5:0] flags;

  acc_wr_if wr_in ();
  acc_wr_if wr_out ();

  // Next read pointer; fast read skips the low sample bytes.
  function automatic logic [7:0] next_ptr(input logic [7:0] p,
                                          input logic fast);
    logic [7:0] n;
    n = p + 8'h01;
    if (p == `ACC_PTR_Z_LSB)
    begin
      n = `ACC_PTR_STATUS;
    end
    else if (fast)
    begin
      case (p)
        `ACC_PTR_X_MSB: n = `ACC_PTR_Y_MSB;
        `ACC_PTR_Y_MSB: n = `ACC_PTR_Z_MSB;
        `ACC_PTR_X_LSB, `ACC_PTR_Y_LSB, `ACC_PTR_Z_MSB: n = `ACC_PTR_STATUS;
        default: n = p + 8'h01;
      endcase
    end
    return n;
  endfunction

  // Reset is released through two flip-flops.
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_sync_reg <= 2'b00;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign scl_rise = st_reg.scl_s & ~st_reg.scl_d;
  assign scl_fall = ~st_reg.scl_s & st_reg.scl_d;
  assign start_cond = st_reg.scl_s & st_reg.scl_d & st_reg.sda_d
    & ~st_reg.sda_s;
  assign stop_cond = st_reg.scl_s & st_reg.scl_d & ~st_reg.sda_d
    & st_reg.sda_s;
  assign flags = {ev_flags_i[5:1], st_reg.drdy};

  assign wr_in.valid = st_reg.push;
  assign wr_in.word = st_reg.push_word;

  acc_fifo2 acc_fifo2_i
  (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .in_if(wr_in),
    .out_if(wr_out)
  );

  assign wr_valid_o = wr_out.valid;
  assign wr_addr_o = wr_out.word.addr;
  assign wr_data_o = wr_out.word.data;
  assign wr_out.ready = wr_ready_i;

  assign sda_o = 1'b0;
  assign sda_oe_o = st_reg.oe;
  assign reg_addr_o = st_reg.ptr;
  assign reg_rd_stb_o = st_reg.rd_stb;
  assign drdy_o = st_reg.drdy;
  assign irq_out_a_o = st_reg.irq_a;
  assign irq_out_b_o = st_reg.irq_b;

  always_comb
  begin
    st_next = st_reg;
    st_next.scl_m = scl_i;
    st_next.scl_s = st_reg.scl_m;
    st_next.scl_d = st_reg.scl_s;
    st_next.sda_m = sda_i;
    st_next.sda_s = st_reg.sda_m;
    st_next.sda_d = st_reg.sda_s;
    st_next.sel_m = addr_lsb_select_i;
    st_next.sel_s = st_reg.sel_m;
    st_next.push = 1'b0;
    st_next.rd_stb = 1'b0;

    // Each enabled source drives exactly one pin chosen by its route bit.
    st_next.irq_a = |(flags & ev_enable_i & ev_route_a_i);
    st_next.irq_b = |(flags & ev_enable_i & ~ev_route_a_i);

    if (start_cond)
    begin
      st_next.state = acc_pkg::ST_ADDR;
      st_next.cnt = `ACC_CNT_RESET;
      st_next.oe = 1'b0;
    end
    else if (stop_cond)
    begin
      st_next.state = acc_pkg::ST_IDLE;
      st_next.oe = 1'b0;
    end
    else
    begin
      case (st_reg.state)
        acc_pkg::ST_IDLE:
        begin
          st_next.oe = 1'b0;
        end
        acc_pkg::ST_ADDR:
        begin
          if (scl_rise && st_reg.cnt != `ACC_BITS_PER_BYTE)
          begin
            st_next.sh = {st_reg.sh[6:0], st_reg.sda_s};
            st_next.cnt = st_reg.cnt + 4'h1;
          end
          else if (scl_fall && st_reg.cnt == `ACC_BITS_PER_BYTE)
          begin
            if (st_reg.sh[7:1] == {`ACC_ADDR_UPPER, st_reg.sel_s})
            begin
              st_next.state = acc_pkg::ST_ACK_ADDR;
              st_next.rw = st_reg.sh[0];
              st_next.oe = 1'b1;
            end
            else
            begin
              st_next.state = acc_pkg::ST_IGNORE;
            end
          end
        end
        acc_pkg::ST_ACK_ADDR:
        begin
          if (scl_fall)
          begin
            st_next.cnt = `ACC_CNT_RESET;
            if (st_reg.rw)
            begin
              // Load the pointed register and put out its top bit.
              st_next.state = acc_pkg::ST_TX;
              st_next.sh = reg_rdata_i;
              st_next.oe = ~reg_rdata_i[7];
              st_next.rd_stb = 1'b1;
            end
            else
            begin
              st_next.state = acc_pkg::ST_RX;
              st_next.first = 1'b1;
              st_next.oe = 1'b0;
            end
          end
        end
        acc_pkg::ST_RX:
        begin
          if (scl_rise && st_reg.cnt != `ACC_BITS_PER_BYTE)
          begin
            st_next.sh = {st_reg.sh[6:0], st_reg.sda_s};
            st_next.cnt = st_reg.cnt + 4'h1;
          end
          else if (scl_fall && st_reg.cnt == `ACC_BITS_PER_BYTE)
          begin
            if (st_reg.first)
            begin
              st_next.ptr = st_reg.sh;
              st_next.first = 1'b0;
              st_next.state = acc_pkg::ST_ACK_RX;
              st_next.oe = 1'b1;
            end
            else if (wr_in.ready)
            begin
              st_next.push = 1'b1;
              st_next.push_word.addr = st_reg.ptr;
              st_next.push_word.data = st_reg.sh;
              st_next.ptr = st_reg.ptr + 8'h01;
              st_next.state = acc_pkg::ST_ACK_RX;
              st_next.oe = 1'b1;
            end
            else
            begin
              // A full buffer refuses the byte with a no-acknowledge.
              st_next.state = acc_pkg::ST_IGNORE;
            end
          end
        end
        acc_pkg::ST_ACK_RX:
        begin
          if (scl_fall)
          begin
            st_next.oe = 1'b0;
            st_next.cnt = `ACC_CNT_RESET;
            st_next.state = acc_pkg::ST_RX;
          end
        end
        acc_pkg::ST_TX:
        begin
          if (scl_fall)
          begin
            if (st_reg.cnt == `ACC_LAST_BIT)
            begin
              st_next.oe = 1'b0;
              st_next.state = acc_pkg::ST_ACK_TX;
              st_next.go_on = 1'b0;
              st_next.ptr = next_ptr(st_reg.ptr, fast_read_i);
            end
            else
            begin
              st_next.sh = {st_reg.sh[6:0], 1'b0};
              st_next.oe = ~st_reg.sh[6];
              st_next.cnt = st_reg.cnt + 4'h1;
            end
          end
        end
        acc_pkg::ST_ACK_TX:
        begin
          if (scl_rise)
          begin
            st_next.go_on = ~st_reg.sda_s;
          end
          else if (scl_fall)
          begin
            st_next.cnt = `ACC_CNT_RESET;
            if (st_reg.go_on)
            begin
              st_next.state = acc_pkg::ST_TX;
              st_next.sh = reg_rdata_i;
              st_next.oe = ~reg_rdata_i[7];
              st_next.rd_stb = 1'b1;
            end
            else
            begin
              st_next.state = acc_pkg::ST_IGNORE;
            end
          end
        end
        acc_pkg::ST_IGNORE:
        begin
          st_next.oe = 1'b0;
        end
        default:
        begin
          st_next.state = acc_pkg::ST_IDLE;
          st_next.oe = 1'b0;
        end
      endcase
    end

    // Data-ready: a fresh sample sets it, a status read clears it; set wins.
    if (st_reg.rd_stb && st_reg.ptr == `ACC_PTR_STATUS)
    begin
      st_next.drdy = 1'b0;
    end
    if (sample_ready_i)
    begin
      st_next.drdy = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.scl_m <= 1'b1;
      st_reg.scl_s <= 1'b1;
      st_reg.scl_d <= 1'b1;
      st_reg.sda_m <= 1'b1;
      st_reg.sda_s <= 1'b1;
      st_reg.sda_d <= 1'b1;
      st_reg.state <= acc_pkg::ST_IDLE;
      st_reg.ptr <= `ACC_PTR_RESET;
      st_reg.sh <= `ACC_BYTE_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule

// ---- include/acc_map.svh ----
/*
  Constants of the accelerometer serial slave port: bus address, register
  pointer values and reset values. Assumes nothing of its includer.
*/
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// Upper six bits of the seven-bit slave address.
`define ACC_ADDR_UPPER 6'h0E
// Register pointer values used by the read pointer sequence.
`define ACC_PTR_STATUS 8'h00
`define ACC_PTR_X_MSB 8'h01
`define ACC_PTR_X_LSB 8'h02
`define ACC_PTR_Y_MSB 8'h03
`define ACC_PTR_Y_LSB 8'h04
`define ACC_PTR_Z_MSB 8'h05
`define ACC_PTR_Z_LSB 8'h06
// Reset values.
`define ACC_PTR_RESET 8'h00
`define ACC_BYTE_RESET 8'h00
`define ACC_CNT_RESET 4'h0
// Bits in a byte, counted from zero.
`define ACC_LAST_BIT 4'h7
`define ACC_BITS_PER_BYTE 4'h8
// Buffer depth in words.
`define ACC_BUF_DEPTH 2

`endif

// ---- include/acc_pkg.sv ----
/*
  Types shared by the accelerometer serial slave port and its write buffer.
  Assumes the map header is compiled alongside.
*/
package acc_pkg;

  typedef enum logic [7:0]
  {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_ACK_ADDR = 8'h04,
    ST_RX = 8'h08,
    ST_ACK_RX = 8'h10,
    ST_TX = 8'h20,
    ST_ACK_TX = 8'h40,
    ST_IGNORE = 8'h80
  } acc_state_e;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] data;
  } acc_word_s;

endpackage

// ---- include/acc_wr_if.sv ----
/*
  Valid and ready carrier of register writes between the port and its buffer.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface acc_wr_if;
  logic valid;
  logic ready;
  acc_pkg::acc_word_s word;

  modport src
  (
    output valid,
    output word,
    input ready
  );

  modport snk
  (
    input valid,
    input word,
    output ready
  );
endinterface

// ---- src/acc_fifo2.sv ----
/*
  Two-entry buffer for register writes with valid and ready on both sides.
  Assumes an asynchronous active-low reset already released cleanly.
*/
`timescale 1ns/1ps
`include "acc_map.svh"
module acc_fifo2
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  acc_wr_if.snk in_if,
  acc_wr_if.src out_if
);

  typedef struct packed
  {
    acc_pkg::acc_word_s [`ACC_BUF_DEPTH-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] count;
  } acc_fifo_s;

  acc_fifo_s st_reg;
  acc_fifo_s st_next;
  logic push;
  logic pop;

  assign in_if.ready = (st_reg.count != 2'd2);
  assign out_if.valid = (st_reg.count != 2'd0);
  assign out_if.word = st_reg.mem[st_reg.rp];
  assign push = in_if.valid & in_if.ready;
  assign pop = out_if.valid & out_if.ready;

  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.mem[st_reg.wp] = in_if.word;
      st_next.wp = ~st_reg.wp;
    end
    if (pop)
    begin
      st_next.rp = ~st_reg.rp;
    end
    if (push && !pop)
    begin
      st_next.count = st_reg.count + 2'd1;
    end
    else if (pop && !push)
    begin
      st_next.count = st_reg.count - 2'd1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule

// ---- tb/acc_i2c_port_checker.sv ----
/*
  Concurrent checks on the ports of the serial slave port.
  Assumes one clock domain and the bench's 400 ns bus clock.
*/
`timescale 1ns/1ps
module acc_i2c_port_checker
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic addr_lsb_select_i,
  input wire logic fast_read_i,
  input wire logic [7:0] reg_addr_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rd_stb_o,
  input wire logic wr_valid_o,
  input wire logic [7:0] wr_addr_o,
  input wire logic [7:0] wr_data_o,
  input wire logic wr_ready_i,
  input wire logic sample_ready_i,
  input wire logic [5:0] ev_flags_i,
  input wire logic [5:0] ev_enable_i,
  input wire logic [5:0] ev_route_a_i,
  input wire logic drdy_o,
  input wire logic irq_out_a_o,
  input wire logic irq_out_b_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_SDA_OPEN: assert property (sda_o == 1'b0)
    else $error("SDA driven high");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe_o) |->
    !$past(scl_i, 2)) else $error("SDA changed while SCL high");
  AST_OE_HOLD: assert property ($rose(sda_oe_o) |->
    sda_oe_o [*4]) else $error("SDA pull too short");
  AST_OE_BOUND: assert property ($rose(sda_oe_o) |->
    ##[1:80] !sda_oe_o) else $error("SDA pull never released");
  AST_WR_HOLD: assert property (wr_valid_o && !wr_ready_i |=>
    wr_valid_o && $stable({wr_addr_o, wr_data_o}))
    else $error("Stalled write word changed");
  AST_DRDY_SET: assert property (sample_ready_i |=> drdy_o)
    else $error("Data ready not set");
  AST_DRDY_CLR: assert property (reg_rd_stb_o &&
    reg_addr_o == 8'h00 && !sample_ready_i |=> !drdy_o)
    else $error("Data ready not cleared");
  AST_DRDY_KEEP: assert property (drdy_o &&
    !(reg_rd_stb_o && reg_addr_o == 8'h00) |=> drdy_o)
    else $error("Data ready lost");
  AST_IRQ_A: assert property (!$past(ev_enable_i[0]) |->
    irq_out_a_o == |($past(ev_flags_i) & $past(ev_enable_i) &
    $past(ev_route_a_i) & 6'h3E)) else $error("Pin A wrong");
  AST_IRQ_B: assert property (!$past(ev_enable_i[0]) |->
    irq_out_b_o == |($past(ev_flags_i) & $past(ev_enable_i) &
    ~$past(ev_route_a_i) & 6'h3E)) else $error("Pin B wrong");
endmodule

bind acc_i2c_port acc_i2c_port_checker acc_i2c_port_checker_i
(
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .addr_lsb_select_i(addr_lsb_select_i), .fast_read_i(fast_read_i),
  .reg_addr_o(reg_addr_o), .reg_rdata_i(reg_rdata_i),
  .reg_rd_stb_o(reg_rd_stb_o), .wr_valid_o(wr_valid_o),
  .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_ready_i(wr_ready_i),
  .sample_ready_i(sample_ready_i), .ev_flags_i(ev_flags_i),
  .ev_enable_i(ev_enable_i), .ev_route_a_i(ev_route_a_i),
  .drdy_o(drdy_o), .irq_out_a_o(irq_out_a_o), .irq_out_b_o(irq_out_b_o)
);

// ---- tb/acc_host_model.sv ----
/*
  Behavioural bus master that drives SCL and pulls SDA low.
  Assumes the bench resolves SDA with a pull-up.
*/
`timescale 1ns/1ps
module acc_host_model
(
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  int half = 200;

  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic start();
    sda_oe_o = 1'b0;
    #(half) scl_o = 1'b1;
    #(half) sda_oe_o = 1'b1;
    #(half) scl_o = 1'b0;
  endtask

  task automatic stop();
    #(half / 2) sda_oe_o = 1'b1;
    #(half / 2) scl_o = 1'b1;
    #(half) sda_oe_o = 1'b0;
    #(half);
  endtask

  task automatic put_bit(input logic b, output logic s);
    #(half / 2) sda_oe_o = !b;
    #(half / 2) scl_o = 1'b1;
    #(half) s = sda_i;
    scl_o = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(ack_in, ack);
  endtask
endmodule

// ---- tb/acc_i2c_port_test.sv ----
/*
  Self-checking bench of the serial slave port with a host model.
  Assumes the bench itself acts as register file and write sink.
*/
`timescale 1ns/1ps
module acc_i2c_port_test;
  logic ref_clk, reset_n, scl, sda, dut_sda, dut_oe, host_oe;
  logic sel, fast, rd_stb, wr_valid, wr_ready, sample_ready;
  logic drdy, irq_a, irq_b;
  logic [7:0] reg_addr, reg_rdata, wr_addr, wr_data;
  logic [5:0] ev_flags, ev_enable, ev_route_a;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  assign sda = (dut_oe ? dut_sda : 1'b1) & !host_oe;
  assign reg_rdata = reg_addr ^ 8'h5C;

  acc_i2c_port acc_i2c_port_i
  (
    .ref_clk_i(ref_clk), .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda),
    .sda_o(dut_sda), .sda_oe_o(dut_oe), .addr_lsb_select_i(sel),
    .fast_read_i(fast), .reg_addr_o(reg_addr), .reg_rdata_i(reg_rdata),
    .reg_rd_stb_o(rd_stb), .wr_valid_o(wr_valid), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .wr_ready_i(wr_ready),
    .sample_ready_i(sample_ready), .ev_flags_i(ev_flags),
    .ev_enable_i(ev_enable), .ev_route_a_i(ev_route_a), .drdy_o(drdy),
    .irq_out_a_o(irq_a), .irq_out_b_o(irq_b)
  );

  acc_host_model acc_host_model_i
  (
    .sda_i(sda),
    .scl_o(scl),
    .sda_oe_o(host_oe)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // The whole run needs about 2300 cycles.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic [7:0] b, input logic exp_nak);
    logic [7:0] rx;
    logic ack;
    acc_host_model_i.xfer(b, 1'b1, rx, ack);
    check({7'h00, ack}, {7'h00, exp_nak});
  endtask

  task automatic rb(input logic nak, input logic [7:0] exp);
    logic [7:0] rx;
    logic ack;
    acc_host_model_i.xfer(8'hFF, nak, rx, ack);
    check(rx, exp);
  endtask

  task automatic pop(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk) #1;
    while (wr_valid !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk) #1;
      n++;
    end
    check({7'h00, wr_valid}, 8'h01);
    check(wr_addr, a);
    check(wr_data, d);
    wr_ready = 1'b1;
    @(posedge ref_clk) #1;
    wr_ready = 1'b0;
  endtask

  task automatic set_pins(input logic s, input logic f);
    @(posedge ref_clk) #1;
    sel = s;
    fast = f;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_write();
    set_pins(1'b0, 1'b0);
    acc_host_model_i.start();
    wb(8'h38, 1'b0);
    wb(8'h10, 1'b0);
    wb(8'h5A, 1'b0);
    wb(8'h5B, 1'b0);
    wb(8'h5C, 1'b1);
    acc_host_model_i.stop();
    pop(8'h10, 8'h5A);
    pop(8'h11, 8'h5B);
    check({7'h00, wr_valid}, 8'h00);
  endtask

  task automatic t_read(input logic f, input logic [7:0] p,
                        input logic [7:0] e0, input logic [7:0] e1);
    set_pins(1'b1, f);
    acc_host_model_i.start();
    wb(8'h3A, 1'b0);
    wb(p, 1'b0);
    acc_host_model_i.start();
    wb(8'h3B, 1'b0);
    rb(1'b0, p ^ 8'h5C);
    rb(1'b0, e0 ^ 8'h5C);
    rb(1'b0, e1 ^ 8'h5C);
    rb(1'b1, 8'h00 ^ 8'h5C);
    acc_host_model_i.stop();
  endtask

  task automatic t_mismatch();
    set_pins(1'b0, 1'b0);
    acc_host_model_i.start();
    wb(8'h3A, 1'b1);
    wb(8'h00, 1'b1);
    acc_host_model_i.start();
    wb(8'h38, 1'b0);
    wb(8'h20, 1'b0);
    wb(8'h77, 1'b0);
    acc_host_model_i.stop();
    pop(8'h20, 8'h77);
  endtask

  task automatic t_irq();
    for (int i = 1; i < 6; i++)
      for (int r = 0; r < 3; r++)
      begin
        @(posedge ref_clk) #1;
        ev_flags = 6'(1 << i);
        ev_enable = (r == 2) ? 6'h00 : 6'(1 << i);
        ev_route_a = (r == 1) ? 6'(1 << i) : 6'h00;
        repeat (3) @(posedge ref_clk);
        #1 check({6'h00, irq_a, irq_b}, {6'h00, r == 1, r == 0});
      end
    ev_flags = 6'h00;
    ev_enable = 6'h01;
    ev_route_a = 6'h01;
    @(posedge ref_clk) #1;
    sample_ready = 1'b1;
    @(posedge ref_clk) #1;
    sample_ready = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 check({6'h00, drdy, irq_a}, 8'h03);
    set_pins(1'b0, 1'b0);
    acc_host_model_i.start();
    wb(8'h38, 1'b0);
    wb(8'h00, 1'b0);
    acc_host_model_i.start();
    wb(8'h39, 1'b0);
    rb(1'b1, 8'h5C);
    acc_host_model_i.stop();
    check({6'h00, drdy, irq_a}, 8'h00);
  endtask

  initial
  begin
    reset_n = 1'b0;
    sel = 1'b0;
    fast = 1'b0;
    wr_ready = 1'b0;
    sample_ready = 1'b0;
    ev_flags = 6'h00;
    ev_enable = 6'h00;
    ev_route_a = 6'h00;
    repeat (20) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (10) @(posedge ref_clk);
    t_write();
    t_read(1'b0, 8'h04, 8'h05, 8'h06);
    t_read(1'b1, 8'h01, 8'h03, 8'h05);
    t_mismatch();
    t_irq();
    give_verdict();
  end
endmodule
